// *** inc/pnp_pkg.sv ***
// How it works
// - card holds a 72-bit identifier: 32-bit vendor, 32-bit serial, 8-bit checksum
// - identifier bytes go out bit 0 first through bit 7; resource bytes go out whole, all eight bits at once
// - isolation pass is 72 read pairs on the read-data port, one bit each
// - a one bit drives 55h then aah on all eight data lines
// - a zero bit floats the driver and samples data[1:0] for 01 then 10
// - a floating card seeing both patterns drops out but may try again later
// - otherwise the card advances one identifier bit per pair through all 72
// - cards with a card number skip isolation; configuration needs a number write or a matching wake
// - exactly four states: wait for key, sleep, isolation, configuration
// - reset drive or wait-for-key command forces wait for key; reset clears number
// - reset-number commands clear the card number, the vendor one on this card too
// - microcontroller loads 64-byte sram: length, isolation data, resource data
// - resource read returns sram byte, increments; wraps past length; reset sets 1
// - after reset clear number, load sram, enter wait for key; host waits 2 ms
// - wait for key ignores all accesses until the key, then sleeps
// - in sleep, wake with 00h sends number-zero cards to isolation, pointer reset
// - winner stays isolated, losers sleep; number write configures; wake 0 sleeps
// - resource data only in configuration; after a wake read 9 id bytes first
// - key is 32 writes to the address port; mismatch restarts matching
package pnp_pkg;
    typedef enum logic [1:0] {
        ST_WAIT_KEY = 2'b00,
        ST_SLEEP    = 2'b01,
        ST_ISOLATE  = 2'b11,
        ST_CONFIG   = 2'b10
    } card_state_e;

    localparam logic [11:0] ADDR_PORT   = 12'h279;
    localparam logic [11:0] WDATA_PORT  = 12'hA79;
    localparam logic [7:0]  IDX_SET_RD  = 8'h00;
    localparam logic [7:0]  IDX_ISOLATE = 8'h01;
    localparam logic [7:0]  IDX_CTRL    = 8'h02;
    localparam logic [7:0]  IDX_WAKE    = 8'h03;
    localparam logic [7:0]  IDX_RES     = 8'h04;
    localparam logic [7:0]  IDX_STATUS  = 8'h05;
    localparam logic [7:0]  IDX_CSN     = 8'h06;
    localparam int CTRL_WAIT_KEY_BIT = 1;
    localparam int CTRL_CLR_CSN_BIT  = 2;
    localparam int CTRL_VENDOR_CLR_BIT = 3;
    localparam logic [7:0]  PAT_FIRST   = 8'h55;
    localparam logic [7:0]  PAT_SECOND  = 8'hAA;
    localparam logic [1:0]  SNIFF_FIRST = 2'b01;
    localparam logic [1:0]  SNIFF_SECOND = 2'b10;
    localparam logic [7:0]  STATUS_READY = 8'h01;
    localparam logic [6:0]  ID_BITS     = 7'h48;
    localparam logic [5:0]  ID_BASE     = 6'h01;
    localparam logic [5:0]  RES_START   = 6'h0A;
    localparam logic [5:0]  PTR_RESET   = 6'h01;
    localparam logic [7:0]  RD_PORT_RESET = 8'h80;
    localparam int          SRAM_BYTES  = 64;
    localparam int          FIFO_DEPTH  = 8;
    localparam logic [4:0]  KEY_LAST    = 5'h1F;
    localparam logic [7:0]  KEY_FIRST   = 8'h6A;

    // each key byte follows from the last by a one-bit feedback shift
    function automatic logic [7:0] key_next(input logic [7:0] b);
        return {b[1] ^ b[0], b[7:1]};
    endfunction
endpackage

// *** inc/pnp_stream.sv ***
`timescale 1ns/1ps
interface pnp_stream #(parameter int W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// *** design/pnp_fifo.sv ***
`timescale 1ns/1ps
module pnp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // stream sides
    pnp_stream.snk   in_s,
    pnp_stream.src   out_s
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]    count_q, count_d;
    logic             ready_q, ready_d;
    logic             push, pop;

    assign in_s.ready  = ready_q;
    assign out_s.valid = (count_q != '0);
    assign out_s.data  = mem_q[rd_q];

    always_comb begin
        push    = in_s.valid && ready_q;
        pop     = out_s.ready && (count_q != '0);
        mem_d   = mem_q;
        wr_d    = wr_q;
        rd_d    = rd_q;
        if (push) begin
            mem_d[wr_q] = in_s.data;
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        count_d = count_q + CW'(push) - CW'(pop);
        // ready is registered from the next count so the source sees a flop, with no slot of slack lost
        ready_d = (count_d != CW'(DEPTH));
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
            ready_q <= 1'b1;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            count_q <= count_d;
            ready_q <= ready_d;
        end
        mem_q <= mem_d;
    end
endmodule

// *** design/pnp_key_match.sv ***
`timescale 1ns/1ps
module pnp_key_match import pnp_pkg::*; (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // address port writes
    input wire logic       wr,
    input wire logic [7:0] data,
    input wire logic       arm,
    // result
    output logic           found
);
    logic [4:0] count_q, count_d;
    logic [7:0] expect_q, expect_d;
    logic       found_q, found_d;

    assign found = found_q;

    always_comb begin
        count_d  = count_q;
        expect_d = expect_q;
        found_d  = 1'b0;
        if (!arm) begin
            count_d  = '0;
            expect_d = KEY_FIRST;
        end else if (wr) begin
            if (data == expect_q) begin
                if (count_q == KEY_LAST) begin
                    found_d  = 1'b1;
                    count_d  = '0;
                    expect_d = KEY_FIRST;
                end else begin
                    count_d  = count_q + 1'b1;
                    expect_d = key_next(expect_q);
                end
            end else if (data == KEY_FIRST) begin
                // a stray byte may itself be the start of a fresh key
                count_d  = 5'h01;
                expect_d = key_next(KEY_FIRST);
            end else begin
                count_d  = '0;
                expect_d = KEY_FIRST;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_q  <= '0;
            expect_q <= KEY_FIRST;
            found_q  <= 1'b0;
        end else begin
            count_q  <= count_d;
            expect_q <= expect_d;
            found_q  <= found_d;
        end
    end
endmodule

// *** design/isa_pnp_isolation_engine.sv ***
`timescale 1ns/1ps
module isa_pnp_isolation_engine import pnp_pkg::*; (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // isa bus pins
    input wire logic        reset_drive,
    input wire logic [11:0] isa_addr,
    input wire logic        isa_ior_n,
    input wire logic        isa_iow_n,
    input wire logic [7:0]  isa_data_in,
    output logic [7:0]      isa_data_out,
    output logic            isa_data_oe_n,
    // microcontroller load port
    input wire logic [7:0]  mcu_data,
    input wire logic        mcu_valid,
    output logic            mcu_ready,
    // card status
    output logic [1:0]      card_state,
    output logic [7:0]      card_number
);
    // two-stage synchronisers; stage two feeds logic, plus a third stage on ior and iow for edge detection
    logic [11:0] addr_s1, addr_s2;
    logic [7:0]  din_s1, din_s2;
    logic        ior_s1, ior_s2, ior_s3;
    logic        iow_s1, iow_s2, iow_s3;
    logic        rdrv_s1, rdrv_s2;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_s1 <= '0;
            addr_s2 <= '0;
            din_s1  <= '0;
            din_s2  <= '0;
            ior_s1  <= 1'b1;
            ior_s2  <= 1'b1;
            ior_s3  <= 1'b1;
            iow_s1  <= 1'b1;
            iow_s2  <= 1'b1;
            iow_s3  <= 1'b1;
            rdrv_s1 <= 1'b0;
            rdrv_s2 <= 1'b0;
        end else begin
            addr_s1 <= isa_addr;
            addr_s2 <= addr_s1;
            din_s1  <= isa_data_in;
            din_s2  <= din_s1;
            ior_s1  <= isa_ior_n;
            ior_s2  <= ior_s1;
            ior_s3  <= ior_s2;
            iow_s1  <= isa_iow_n;
            iow_s2  <= iow_s1;
            iow_s3  <= iow_s2;
            rdrv_s1 <= reset_drive;
            rdrv_s2 <= rdrv_s1;
        end
    end

    card_state_e state_q, state_d;
    logic [7:0]  csn_q, csn_d;
    logic [7:0]  idx_q, idx_d;
    logic [7:0]  rdport_q, rdport_d;
    logic [5:0]  ptr_q, ptr_d;
    logic [6:0]  bit_q, bit_d;
    logic        phase_q, phase_d;
    logic        seen_q, seen_d;
    logic [7:0]  dout_q, dout_d;
    logic        oe_n_q, oe_n_d;
    logic [5:0]  ld_q, ld_d;
    logic [7:0]  mem_q [SRAM_BYTES];
    logic [7:0]  mem_d [SRAM_BYTES];

    logic        ior_fall, ior_rise, iow_rise;
    logic        hit_rd, hit_addr, hit_wdata;
    logic        id_bit, sniff, key_found;
    logic [5:0]  id_index, res_ptr;

    assign ior_fall  = ior_s3 && !ior_s2;
    assign ior_rise  = !ior_s3 && ior_s2;
    assign iow_rise  = !iow_s3 && iow_s2;
    assign hit_rd    = (addr_s2 == {2'b00, rdport_q, 2'b11});
    assign hit_addr  = (addr_s2 == ADDR_PORT);
    assign hit_wdata = (addr_s2 == WDATA_PORT);
    // identifier bits live in sram bytes 1..9, bit 0 of each byte first
    assign id_index  = ID_BASE + {2'b00, bit_q[6:3]};
    assign id_bit    = mem_q[id_index][bit_q[2:0]];
    // a read at the stored length already serves the first resource byte, never a stale slot
    assign res_ptr   = (ptr_q == mem_q[0][5:0]) ? RES_START : ptr_q;
    assign sniff     = phase_q ? (din_s2[1:0] == SNIFF_SECOND)
                               : (din_s2[1:0] == SNIFF_FIRST);

    pnp_stream #(.W(8)) load_in ();
    pnp_stream #(.W(8)) load_out ();

    assign load_in.data  = mcu_data;
    assign load_in.valid = mcu_valid;
    assign mcu_ready     = load_in.ready;
    // sram loading yields to an isa read completing in the same cycle
    assign load_out.ready = !ior_rise;

    pnp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock (clock),
        .rst_n (rst_n),
        .in_s  (load_in),
        .out_s (load_out)
    );

    pnp_key_match u_key (
        .clock (clock),
        .rst_n (rst_n),
        .wr    (iow_rise && hit_addr),
        .data  (din_s2),
        .arm   (state_q == ST_WAIT_KEY),
        .found (key_found)
    );

    always_comb begin
        state_d  = state_q;
        csn_d    = csn_q;
        idx_d    = idx_q;
        rdport_d = rdport_q;
        ptr_d    = ptr_q;
        bit_d    = bit_q;
        phase_d  = phase_q;
        seen_d   = seen_q;
        dout_d   = dout_q;
        oe_n_d   = oe_n_q;
        ld_d     = ld_q;
        mem_d    = mem_q;

        // byte 0 is frame length, then isolation data, then resource data
        if (load_out.valid && load_out.ready) begin
            mem_d[ld_q] = load_out.data;
            ld_d = ld_q + 1'b1;
        end

        if (ior_fall && hit_rd && state_q != ST_WAIT_KEY) begin
            oe_n_d = 1'b1;
            if (idx_q == IDX_ISOLATE && state_q == ST_ISOLATE && bit_q != ID_BITS) begin
                if (id_bit) begin
                    dout_d = phase_q ? PAT_SECOND : PAT_FIRST;
                    oe_n_d = 1'b0;
                end
            end else if (state_q == ST_CONFIG) begin
                if (idx_q == IDX_RES) begin
                    dout_d = mem_q[res_ptr];
                    oe_n_d = 1'b0;
                end else if (idx_q == IDX_STATUS) begin
                    dout_d = STATUS_READY;
                    oe_n_d = 1'b0;
                end else if (idx_q == IDX_CSN) begin
                    dout_d = csn_q;
                    oe_n_d = 1'b0;
                end
            end
        end

        if (ior_rise) begin
            oe_n_d = 1'b1;
            if (hit_rd && idx_q == IDX_ISOLATE && state_q == ST_ISOLATE
                && bit_q != ID_BITS) begin
                phase_d = !phase_q;
                if (!phase_q) begin
                    seen_d = !id_bit && sniff;
                end else if (!id_bit && seen_q && sniff) begin
                    // lost this round; rejoin at the next wake
                    state_d = ST_SLEEP;
                    bit_d   = '0;
                    phase_d = 1'b0;
                end else begin
                    bit_d = bit_q + 1'b1;
                end
            end else if (hit_rd && idx_q == IDX_RES && state_q == ST_CONFIG) begin
                ptr_d = res_ptr + 1'b1;
            end
        end

        if (state_q == ST_WAIT_KEY) begin
            if (key_found) begin
                state_d = ST_SLEEP;
            end
        end else if (iow_rise && hit_addr) begin
            idx_d = din_s2;
        end else if (iow_rise && hit_wdata) begin
            if (idx_q == IDX_SET_RD && state_q == ST_ISOLATE) begin
                rdport_d = din_s2;
            end else if (idx_q == IDX_CTRL) begin
                if (din_s2[CTRL_CLR_CSN_BIT] || din_s2[CTRL_VENDOR_CLR_BIT]) begin
                    csn_d = '0;
                end
                if (din_s2[CTRL_WAIT_KEY_BIT]) begin
                    state_d = ST_WAIT_KEY;
                end
            end else if (idx_q == IDX_WAKE) begin
                ptr_d   = PTR_RESET;
                bit_d   = '0;
                phase_d = 1'b0;
                if (din_s2 == 8'h00 && csn_q == 8'h00) begin
                    state_d = ST_ISOLATE;
                end else if (din_s2 == csn_q) begin
                    state_d = ST_CONFIG;
                end else begin
                    state_d = ST_SLEEP;
                end
            end else if (idx_q == IDX_CSN) begin
                // in isolation only the card that survived all bits may take a number; a configured card may rewrite it
                if (state_q == ST_ISOLATE && bit_q == ID_BITS) begin
                    csn_d   = din_s2;
                    state_d = ST_CONFIG;
                end else if (state_q == ST_CONFIG) begin
                    csn_d = din_s2;
                end
            end
        end

        if (rdrv_s2) begin
            state_d = ST_WAIT_KEY;
            csn_d   = '0;
            ptr_d   = PTR_RESET;
            bit_d   = '0;
            phase_d = 1'b0;
            oe_n_d  = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q  <= ST_WAIT_KEY;
            csn_q    <= '0;
            idx_q    <= '0;
            rdport_q <= RD_PORT_RESET;
            ptr_q    <= PTR_RESET;
            bit_q    <= '0;
            phase_q  <= 1'b0;
            seen_q   <= 1'b0;
            dout_q   <= '0;
            oe_n_q   <= 1'b1;
            ld_q     <= '0;
        end else begin
            state_q  <= state_d;
            csn_q    <= csn_d;
            idx_q    <= idx_d;
            rdport_q <= rdport_d;
            ptr_q    <= ptr_d;
            bit_q    <= bit_d;
            phase_q  <= phase_d;
            seen_q   <= seen_d;
            dout_q   <= dout_d;
            oe_n_q   <= oe_n_d;
            ld_q     <= ld_d;
        end
        mem_q <= mem_d;
    end

    assign isa_data_out  = dout_q;
    assign isa_data_oe_n = oe_n_q;
    assign card_state    = state_q;
    assign card_number   = csn_q;

    logic iso_read;
    assign iso_read = hit_rd && idx_q == IDX_ISOLATE && state_q == ST_ISOLATE
                      && bit_q != ID_BITS && !rdrv_s2;

    reset_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
        rdrv_s2 |=> state_q == ST_WAIT_KEY && csn_q == 8'h00 && ptr_q == PTR_RESET)
        else $error("reset drive did not force wait for key");
    drive_one_a: assert property (@(posedge clock) disable iff (!rst_n)
        ior_fall && iso_read && id_bit |=> !isa_data_oe_n
        && isa_data_out == ($past(phase_q) ? PAT_SECOND : PAT_FIRST))
        else $error("one bit not driven as pattern");
    float_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        ior_fall && iso_read && !id_bit |=> isa_data_oe_n)
        else $error("zero bit drove the bus");
    bit_advance_a: assert property (@(posedge clock) disable iff (!rst_n)
        ior_rise && iso_read && phase_q && !(!id_bit && seen_q && sniff)
        |=> bit_q == $past(bit_q) + 7'h01)
        else $error("identifier bit did not advance");
    bit_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        ior_rise && iso_read && !phase_q |=> $stable(bit_q) && phase_q)
        else $error("bit moved on first read");
    lose_sleep_a: assert property (@(posedge clock) disable iff (!rst_n)
        ior_rise && iso_read && phase_q && !id_bit && seen_q && sniff
        |=> state_q == ST_SLEEP && bit_q == 7'h00)
        else $error("loser stayed in isolation");
    key_sleep_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == ST_WAIT_KEY && !key_found && !rdrv_s2 |=> state_q == ST_WAIT_KEY)
        else $error("left wait for key without key");
    res_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        ior_fall && hit_rd && idx_q == IDX_RES && state_q != ST_CONFIG |=> isa_data_oe_n)
        else $error("resource data outside configuration");
    ptr_step_a: assert property (@(posedge clock) disable iff (!rst_n)
        ior_rise && hit_rd && idx_q == IDX_RES && state_q == ST_CONFIG && !rdrv_s2
        && ptr_q != mem_q[0][5:0] |=> ptr_q == $past(ptr_q) + 6'h01)
        else $error("resource pointer did not step");
endmodule

// *** testbench/isa_host_model.sv ***
`timescale 1ns/1ps
module isa_host_model import pnp_pkg::*; (
    // clock
    input wire logic        clock,
    // card driver
    input wire logic [7:0]  card_out,
    input wire logic        card_oe_n,
    // bus pins
    output logic [11:0]     addr,
    output logic            ior_n,
    output logic            iow_n,
    output logic [7:0]      bus
);
    logic [7:0] wdata;
    logic       wdrv;
    logic [7:0] rival;
    logic       rival_on;

    initial begin
        addr = 12'h000;
        ior_n = 1'b1;
        iow_n = 1'b1;
        wdata = 8'h00;
        wdrv = 1'b0;
        rival = 8'h00;
        rival_on = 1'b0;
    end

    // data lines carry pull-ups; every driver pulls low, so two drivers give a wired and
    always_comb begin
        bus = 8'hFF;
        if (!card_oe_n) bus = bus & card_out;
        if (rival_on) bus = bus & rival;
        if (wdrv) bus = bus & wdata;
    end

    task automatic io_write(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wdrv <= 1'b1;
        iow_n <= 1'b0;
        repeat (4) @(posedge clock);
        iow_n <= 1'b1;
        repeat (3) @(posedge clock);
        wdrv <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    // rival stands in for a second card driving during the float reads
    task automatic io_read(input logic [11:0] a, input logic ron, input logic [7:0] rv,
                           output logic [7:0] d, output logic oe);
        @(posedge clock);
        addr <= a;
        rival <= rv;
        rival_on <= ron;
        ior_n <= 1'b0;
        repeat (7) @(posedge clock);
        d = bus;
        oe = card_oe_n;
        ior_n <= 1'b1;
        repeat (3) @(posedge clock);
        rival_on <= 1'b0;
        // pair gaps are shortened from the millisecond figures to keep the run brief
        repeat (5) @(posedge clock);
    endtask
endmodule

// *** testbench/isa_pnp_isolation_engine_test.sv ***
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            $display("mismatch %s expected %h seen %h", nm, exp, got); \
            miscompares++; \
        end \
    end
module isa_pnp_isolation_engine_test import pnp_pkg::*;;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        reset_drive = 1'b0;
    logic [11:0] isa_addr;
    logic        isa_ior_n;
    logic        isa_iow_n;
    logic [7:0]  bus;
    logic [7:0]  isa_data_out;
    logic        isa_data_oe_n;
    logic [7:0]  mcu_data = 8'h00;
    logic        mcu_valid = 1'b0;
    logic        mcu_ready;
    logic [1:0]  card_state;
    logic [7:0]  card_number;
    int          miscompares = 0;
    int          samples_checked = 0;
    localparam logic [11:0] RD_PORT = 12'h203;
    // frame: length 13, eight identifier bytes (arbitrary), an xor checksum stand-in,
    // three resource bytes
    logic [7:0]  sram [13] = '{8'h0D, 8'h5A, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A,
                               8'hBC, 8'hDE, 8'hAA, 8'h30, 8'h47, 8'h01};

    always #20 clock = ~clock;

    isa_pnp_isolation_engine isa_pnp_isolation_engine_inst (
        .clock(clock), .rst_n(rst_n), .reset_drive(reset_drive), .isa_addr(isa_addr),
        .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n), .isa_data_in(bus),
        .isa_data_out(isa_data_out), .isa_data_oe_n(isa_data_oe_n), .mcu_data(mcu_data),
        .mcu_valid(mcu_valid), .mcu_ready(mcu_ready), .card_state(card_state),
        .card_number(card_number));

    isa_host_model isa_host_model_inst (
        .clock(clock), .card_out(isa_data_out), .card_oe_n(isa_data_oe_n),
        .addr(isa_addr), .ior_n(isa_ior_n), .iow_n(isa_iow_n), .bus(bus));

    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] idx, input logic [7:0] val);
        isa_host_model_inst.io_write(ADDR_PORT, idx);
        isa_host_model_inst.io_write(WDATA_PORT, val);
    endtask

    task automatic send_key(input int bad);
        logic [7:0] k;
        k = KEY_FIRST;
        for (int i = 0; i < 32; i++) begin
            isa_host_model_inst.io_write(ADDR_PORT, (i == bad) ? 8'h00 : k);
            k = {k[1] ^ k[0], k[7:1]};
        end
    endtask

    task automatic load_byte(input logic [7:0] b);
        int n;
        n = 0;
        mcu_data <= b;
        mcu_valid <= 1'b1;
        @(posedge clock);
        while (mcu_ready !== 1'b1) begin
            n++;
            if (n > 50) begin
                miscompares++;
                complete_run();
            end
            @(posedge clock);
        end
    endtask

    task automatic test_reset_and_key();
        `CHECK("state", ST_WAIT_KEY, card_state)
        `CHECK("number", 8'h00, card_number)
        `CHECK("oe_n", 1'b1, isa_data_oe_n)
        `CHECK("mcu_ready", 1'b1, mcu_ready)
        cmd(IDX_WAKE, 8'h00);
        `CHECK("wake ignored", ST_WAIT_KEY, card_state)
        send_key(10);
        `CHECK("broken key", ST_WAIT_KEY, card_state)
        send_key(99);
        `CHECK("key", ST_SLEEP, card_state)
        $display("test reset_and_key done");
    endtask

    task automatic test_load();
        @(posedge clock);
        for (int i = 0; i < 13; i++) load_byte(sram[i]);
        mcu_valid <= 1'b0;
        repeat (20) @(posedge clock);
        $display("test load done");
    endtask

    // all 72 pairs alone on the bus: every bit is a win
    task automatic test_isolate();
        logic [7:0] d;
        logic       oe;
        logic       b;
        logic [71:0] idv;
        logic [7:0] sum;
        cmd(IDX_WAKE, 8'h00);
        `CHECK("wake state", ST_ISOLATE, card_state)
        isa_host_model_inst.io_write(ADDR_PORT, IDX_ISOLATE);
        for (int n = 0; n < 72; n++) begin
            b = sram[1 + n / 8][n % 8];
            isa_host_model_inst.io_read(RD_PORT, 1'b0, 8'h00, d, oe);
            `CHECK("first oe_n", ~b, oe)
            if (b) `CHECK("first data", PAT_FIRST, d)
            idv[n] = (d == PAT_FIRST);
            isa_host_model_inst.io_read(RD_PORT, 1'b0, 8'h00, d, oe);
            `CHECK("second oe_n", ~b, oe)
            if (b) `CHECK("second data", PAT_SECOND, d)
            idv[n] = idv[n] && (d == PAT_SECOND);
        end
        sum = 8'h00;
        for (int i = 0; i < 8; i++) sum = sum ^ idv[8*i +: 8];
        `CHECK("checksum", sum, idv[71:64])
        `CHECK("winner state", ST_ISOLATE, card_state)
        cmd(IDX_CSN, 8'h01);
        `CHECK("config state", ST_CONFIG, card_state)
        `CHECK("number", 8'h01, card_number)
        $display("test isolate done");
    endtask

    task automatic test_resource();
        logic [7:0] d;
        logic       oe;
        cmd(IDX_WAKE, 8'h01);
        `CHECK("wake match", ST_CONFIG, card_state)
        isa_host_model_inst.io_write(ADDR_PORT, IDX_STATUS);
        isa_host_model_inst.io_read(RD_PORT, 1'b0, 8'h00, d, oe);
        `CHECK("status", STATUS_READY, d)
        isa_host_model_inst.io_write(ADDR_PORT, IDX_RES);
        for (int p = 1; p <= 13; p++) begin
            isa_host_model_inst.io_read(RD_PORT, 1'b0, 8'h00, d, oe);
            `CHECK("resource", sram[(p < 13) ? p : 10], d)
        end
        $display("test resource done");
    endtask

    task automatic test_rival();
        logic [7:0] d;
        logic       oe;
        cmd(IDX_WAKE, 8'h00);
        `CHECK("numbered sleeps", ST_SLEEP, card_state)
        cmd(IDX_CTRL, 8'h04);
        `CHECK("number cleared", 8'h00, card_number)
        cmd(IDX_WAKE, 8'h00);
        `CHECK("isolate", ST_ISOLATE, card_state)
        isa_host_model_inst.io_write(ADDR_PORT, IDX_ISOLATE);
        isa_host_model_inst.io_read(RD_PORT, 1'b1, PAT_FIRST, d, oe);
        `CHECK("float oe_n", 1'b1, oe)
        isa_host_model_inst.io_read(RD_PORT, 1'b1, PAT_SECOND, d, oe);
        `CHECK("loser state", ST_SLEEP, card_state)
        isa_host_model_inst.io_write(ADDR_PORT, IDX_RES);
        isa_host_model_inst.io_read(RD_PORT, 1'b0, 8'h00, d, oe);
        `CHECK("resource refused", 1'b1, oe)
        cmd(IDX_WAKE, 8'h00);
        `CHECK("eligible again", ST_ISOLATE, card_state)
        cmd(IDX_CTRL, 8'h02);
        `CHECK("wait key cmd", ST_WAIT_KEY, card_state)
        $display("test rival done");
    endtask

    task automatic test_reset_drive();
        logic [7:0] d;
        logic       oe;
        send_key(99);
        cmd(IDX_WAKE, 8'h00);
        // move the read-data port as a host does after a conflict
        cmd(IDX_SET_RD, 8'h81);
        isa_host_model_inst.io_write(ADDR_PORT, IDX_ISOLATE);
        for (int n = 0; n < 144; n++) begin
            isa_host_model_inst.io_read(12'h207, 1'b0, 8'h00, d, oe);
        end
        cmd(IDX_CSN, 8'h03);
        cmd(IDX_CTRL, 8'h08);
        `CHECK("vendor clear", 8'h00, card_number)
        cmd(IDX_CSN, 8'h02);
        `CHECK("numbered", 8'h02, card_number)
        isa_host_model_inst.io_write(ADDR_PORT, IDX_CSN);
        isa_host_model_inst.io_read(12'h207, 1'b0, 8'h00, d, oe);
        `CHECK("number read", 8'h02, d)
        @(posedge clock);
        reset_drive <= 1'b1;
        repeat (4) @(posedge clock);
        reset_drive <= 1'b0;
        repeat (4) @(posedge clock);
        `CHECK("drive state", ST_WAIT_KEY, card_state)
        `CHECK("drive number", 8'h00, card_number)
        $display("test reset_drive done");
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (5) @(posedge clock);
        test_reset_and_key();
        test_load();
        test_isolate();
        test_resource();
        test_rival();
        test_reset_drive();
        complete_run();
    end
endmodule
